// ===== verilog/cirq_regs.vh
// Constants for the command and interrupt register block.
// Included by cirq_top.v; holds definitions only.
`ifndef CIRQ_REGS_VH
`define CIRQ_REGS_VH

// Register indices; the byte address is four times the index
`define CIRQ_IDX_RSVD      3'h0
`define CIRQ_IDX_CMD       3'h1
`define CIRQ_IDX_PEN       3'h2
`define CIRQ_IDX_SEN       3'h3
`define CIRQ_IDX_PREQ      3'h4
`define CIRQ_IDX_SREQ      3'h5

// Reset values
`define CIRQ_RST_RSVD      8'h00
`define CIRQ_RST_CMD       8'h20
`define CIRQ_RST_PEN       8'h80
`define CIRQ_RST_SEN       8'h00
`define CIRQ_RST_PREQ      8'h14
`define CIRQ_RST_SREQ      8'h00

// Implemented bits of the secondary enable and both request registers
`define CIRQ_MASK_SEN      8'h94
`define CIRQ_MASK_PREQ     8'h7F
`define CIRQ_MASK_SREQ     8'h14

// Field positions
`define CIRQ_BIT_RCV_OFF   5
`define CIRQ_BIT_SLEEP     4
`define CIRQ_BIT_INVERT    7
`define CIRQ_BIT_PUSHPULL  7
`define CIRQ_BIT_SETSEL    7
`define CIRQ_BIT_EXT_ACT   4
`define CIRQ_BIT_CRC       2
`define CIRQ_BIT_TX        6
`define CIRQ_BIT_RX        5
`define CIRQ_BIT_IDLE      4
`define CIRQ_BIT_HI        3
`define CIRQ_BIT_LO        2
`define CIRQ_BIT_ERR       1
`define CIRQ_BIT_TIMER     0

// Command codes and the set of recognised codes
`define CIRQ_CMD_IDLE      4'h0
`define CIRQ_CMD_SOFTRST   4'hF
`define CIRQ_CMD_KNOWN     16'h80FF

// Wake-up time after leaving soft sleep, and clock period
`define CIRQ_WAKE_NS       1000
`define CIRQ_CLK_NS        5

`endif

// ===== verilog/cirq_top.v
// Command control and interrupt gating registers of a reader frontend.
// Assumes an Avalon-MM master on REF_CLK and one-cycle event pulses
// from the command engines, timer, CRC unit and alert logic.
//
// Behaviour
// - Command control resets to 20h: receiver off, awake, idle command.
// - Bit 5 of command control switches the analog receiver off; read/write.
// - Writing one to bit 4 enters soft sleep.
// - Clearing bit 4 starts wake-up; bit reads one until ready.
// - Setting bit 4 is ignored while the soft-reset command runs.
// - Writing bits 3..0 starts a command; reading shows the running command.
// - Primary enable register at 02h resets to 80h, fully read/write.
// - Enable bit 7 set inverts the pin against the summary status.
// - Reset inversion with open-drain driver leaves the pin undriven.
// - Primary enable bits 6..0 pass their request flags to the pin.
// - Secondary enable at 03h resets to 00h; bits 6,5,3,1,0 reserved.
// - Secondary enable bit 7 selects push-pull, else open-drain pin.
// - Secondary enable bits 4 and 2 gate activity and CRC requests.
// - Primary request at 04h resets to 14h; bit 7 set/clear selector.
// - Register 00h resets to 00h and does nothing.
// - Request write: bit 7 one sets marked flags, zero clears them.
// - Idle flag sets when a command ends; host idle write does not.
// - Unknown command code returns to idle and sets the idle flag.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "cirq_regs.vh"

module cirq_top #(
  parameter [11:0] WAKE_CYCLES = (`CIRQ_WAKE_NS + `CIRQ_CLK_NS - 1) / `CIRQ_CLK_NS,
  parameter [15:0] CMD_KNOWN   = `CIRQ_CMD_KNOWN
) (
  input  wire        REF_CLK,
  input  wire        RST_N,
  input  wire [4:0]  AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [31:0] AVS_WRITEDATA,
  input  wire [3:0]  AVS_BYTEENABLE,
  output wire [31:0] AVS_READDATA,
  output wire        AVS_WAITREQUEST,
  input  wire        CMD_DONE,
  input  wire        TX_DONE_SET,
  input  wire        RX_DONE_SET,
  input  wire        HIGH_ALERT_SET,
  input  wire        LOW_ALERT_SET,
  input  wire        ERROR_SET,
  input  wire        TIMER_EXPIRY_SET,
  input  wire        EXT_INPUT_ACTIVITY_SET,
  input  wire        CRC_DONE_SET,
  output wire [3:0]  COMMAND,
  output wire        CMD_START,
  output wire        RECEIVER_OFF,
  output wire        SOFT_SLEEP,
  output wire        IRQ_O,
  output wire        IRQ_OE
);

  // Reset image of command control, split into its fields at reset
  localparam [7:0] RST_CMD   = `CIRQ_RST_CMD;
  // Bits that exist in each request register; bit 7 only steers writes
  localparam [7:0] PREQ_MASK = `CIRQ_MASK_PREQ;
  localparam [7:0] SREQ_MASK = `CIRQ_MASK_SREQ;

  // Write strobe of one register index; shared by every mapped register
  function cirq_sel;
    input       strobe;
    input [2:0] at;
    input [2:0] want;
    begin
      cirq_sel = strobe & (at == want);
    end
  endfunction

  // Set/clear update of a request register; hardware sets win
  // over a host clear in the same cycle, so no event is lost
  function [7:0] cirq_setclr;
    input [7:0] cur;
    input       hit;
    input [7:0] wd;
    input [7:0] hw;
    input [7:0] mask;
    reg   [7:0] v;
    begin
      v = cur;
      if (hit) begin
        if (wd[`CIRQ_BIT_SETSEL])
          v = v | wd;
        else
          v = v & ~wd;
      end
      cirq_setclr = (v | hw) & mask;
    end
  endfunction

  // State registers
  reg        waitreq_r;
  reg [31:0] rdata_r;
  reg        rcv_off_r;
  reg        sleep_r;
  reg [11:0] wake_cnt_r;
  reg [3:0]  cmd_r;
  reg        cmd_start_r;
  reg [7:0]  pen_r;
  reg [7:0]  sen_r;
  reg [7:0]  preq_r;
  reg [7:0]  sreq_r;
  reg        soft_sleep_r;
  reg        irq_o_r;
  reg        irq_oe_r;

  // Next values
  reg        waitreq_nxt;
  reg [31:0] rdata_nxt;
  reg        rcv_off_nxt;
  reg        sleep_nxt;
  reg [11:0] wake_cnt_nxt;
  reg [3:0]  cmd_nxt;
  reg        cmd_start_nxt;
  reg [7:0]  pen_nxt;
  reg [7:0]  sen_nxt;
  reg [7:0]  preq_nxt;
  reg [7:0]  sreq_nxt;
  reg        soft_sleep_nxt;
  reg        irq_o_nxt;
  reg        irq_oe_nxt;
  reg        idle_set;
  reg [7:0]  rd_byte;

  // Bus decode; only the low byte lane carries register data
  wire [2:0] idx     = AVS_ADDRESS[4:2];
  wire [7:0] wd      = AVS_WRITEDATA[7:0];
  wire       req     = AVS_READ | AVS_WRITE;
  wire       wr      = AVS_WRITE & ~waitreq_r & AVS_BYTEENABLE[0];

  // Write strobes, one per mapped register
  wire       wr_cmd  = cirq_sel(wr, idx, `CIRQ_IDX_CMD);
  wire       wr_pen  = cirq_sel(wr, idx, `CIRQ_IDX_PEN);
  wire       wr_sen  = cirq_sel(wr, idx, `CIRQ_IDX_SEN);
  wire       wr_preq = cirq_sel(wr, idx, `CIRQ_IDX_PREQ);
  wire       wr_sreq = cirq_sel(wr, idx, `CIRQ_IDX_SREQ);

  // Command decode
  wire       waking  = (wake_cnt_r != 12'h000);
  wire       known   = CMD_KNOWN[wd[3:0]];

  // Hardware set vectors in register bit order
  wire [7:0] prim_set = {1'b0, TX_DONE_SET, RX_DONE_SET, idle_set,
                         HIGH_ALERT_SET, LOW_ALERT_SET, ERROR_SET,
                         TIMER_EXPIRY_SET};
  wire [7:0] sec_set  = {3'b000, EXT_INPUT_ACTIVITY_SET, 1'b0,
                         CRC_DONE_SET, 2'b00};

  // Per-bit gating of flags by enables; masks keep reserved bits
  // away from the pin even if a set vector ever fills them
  wire [7:0] prim_hit;
  wire [7:0] sec_hit;
  genvar     gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : gate_bit
      assign prim_hit[gi] = preq_r[gi] & pen_r[gi] & PREQ_MASK[gi];
      assign sec_hit[gi]  = sreq_r[gi] & sen_r[gi] & SREQ_MASK[gi];
    end
  endgenerate

  // Summary status and pin level from the registered flags
  wire       irq_any  = (|prim_hit) | (|sec_hit);
  wire       irq_lvl  = irq_any ^ pen_r[`CIRQ_BIT_INVERT];

  // Bus handshake: one wait cycle, then a single ready cycle; the
  // registered ready keeps the bus answer off any combinational path
  always @* begin
    waitreq_nxt = 1'b1;
    if (req & waitreq_r)
      waitreq_nxt = 1'b0;
  end

  // Read multiplexer; register 00h and unmapped slots read zero
  always @* begin
    rd_byte = 8'h00;
    case (idx)
      `CIRQ_IDX_RSVD: rd_byte = `CIRQ_RST_RSVD;
      `CIRQ_IDX_CMD: begin
        rd_byte = {2'b00, rcv_off_r, sleep_r | waking, cmd_r};
      end
      `CIRQ_IDX_PEN:  rd_byte = pen_r;
      `CIRQ_IDX_SEN:  rd_byte = sen_r & `CIRQ_MASK_SEN;
      `CIRQ_IDX_PREQ: rd_byte = preq_r & `CIRQ_MASK_PREQ;
      `CIRQ_IDX_SREQ: rd_byte = sreq_r & `CIRQ_MASK_SREQ;
      default:        rd_byte = 8'h00;
    endcase
  end

  // Read data is captured as the request is taken and then held,
  // so the master may sample it at the ready edge or later
  always @* begin
    rdata_nxt = rdata_r;
    if (req & waitreq_r)
      rdata_nxt = {24'h000000, rd_byte};
  end

  // Command field, receiver switch and soft sleep
  always @* begin
    rcv_off_nxt   = rcv_off_r;
    sleep_nxt     = sleep_r;
    wake_cnt_nxt  = wake_cnt_r;
    cmd_nxt       = cmd_r;
    cmd_start_nxt = 1'b0;
    idle_set      = 1'b0;
    if (waking)
      wake_cnt_nxt = wake_cnt_r - 12'h001;
    if (wr_cmd) begin
      rcv_off_nxt = wd[`CIRQ_BIT_RCV_OFF];
      if (wd[`CIRQ_BIT_SLEEP]) begin
        // A running soft reset must finish before sleep is allowed
        if (cmd_r != `CIRQ_CMD_SOFTRST) begin
          sleep_nxt    = 1'b1;
          wake_cnt_nxt = 12'h000;
        end
      end else if (sleep_r) begin
        sleep_nxt    = 1'b0;
        wake_cnt_nxt = WAKE_CYCLES;
      end
      if (known) begin
        cmd_nxt       = wd[3:0];
        cmd_start_nxt = (wd[3:0] != `CIRQ_CMD_IDLE);
      end else begin
        cmd_nxt  = `CIRQ_CMD_IDLE;
        idle_set = 1'b1;
      end
    end else if (CMD_DONE & (cmd_r != `CIRQ_CMD_IDLE)) begin
      // Engine finished on its own: back to idle and flag it
      cmd_nxt  = `CIRQ_CMD_IDLE;
      idle_set = 1'b1;
    end
  end

  // Enable registers; reserved secondary bits never store a one,
  // so they read back as zero; the read multiplexer masks them as well
  always @* begin
    pen_nxt = pen_r;
    if (wr_pen)
      pen_nxt = wd;
    sen_nxt = sen_r;
    if (wr_sen)
      sen_nxt = wd & `CIRQ_MASK_SEN;
  end

  // Request flags; the selector bit itself is never stored,
  // it only decides whether marked flags are set or cleared
  always @* begin
    preq_nxt = cirq_setclr(preq_r, wr_preq, wd, prim_set, PREQ_MASK);
    sreq_nxt = cirq_setclr(sreq_r, wr_sreq, wd, sec_set, SREQ_MASK);
  end

  // Pin level for the next edge; open drain only ever pulls low,
  // a released line is left to the board pull-up
  always @* begin
    irq_o_nxt  = 1'b0;
    irq_oe_nxt = 1'b0;
    case (sen_r[`CIRQ_BIT_PUSHPULL])
      1'b1: begin
        irq_o_nxt  = irq_lvl;
        irq_oe_nxt = 1'b1;
      end
      default: begin
        irq_o_nxt  = 1'b0;
        irq_oe_nxt = ~irq_lvl;
      end
    endcase
  end

  // Core stays asleep until the wake-up count has run out; the
  // output follows next state so it moves with the write edge
  always @* begin
    soft_sleep_nxt = sleep_nxt | (wake_cnt_nxt != 12'h000);
  end

  // Bus flops; waitrequest idles high, so every request waits once
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      waitreq_r <= 1'b1;
      rdata_r   <= 32'h00000000;
    end else begin
      waitreq_r <= waitreq_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // Command control flops; reset takes every field from the reset image
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rcv_off_r    <= RST_CMD[`CIRQ_BIT_RCV_OFF];
      sleep_r      <= RST_CMD[`CIRQ_BIT_SLEEP];
      wake_cnt_r   <= 12'h000;
      cmd_r        <= RST_CMD[3:0];
      cmd_start_r  <= 1'b0;
      soft_sleep_r <= RST_CMD[`CIRQ_BIT_SLEEP];
    end else begin
      rcv_off_r    <= rcv_off_nxt;
      sleep_r      <= sleep_nxt;
      wake_cnt_r   <= wake_cnt_nxt;
      cmd_r        <= cmd_nxt;
      cmd_start_r  <= cmd_start_nxt;
      soft_sleep_r <= soft_sleep_nxt;
    end
  end

  // Enable and request flops
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pen_r  <= `CIRQ_RST_PEN;
      sen_r  <= `CIRQ_RST_SEN;
      preq_r <= `CIRQ_RST_PREQ;
      sreq_r <= `CIRQ_RST_SREQ;
    end else begin
      pen_r  <= pen_nxt;
      sen_r  <= sen_nxt;
      preq_r <= preq_nxt;
      sreq_r <= sreq_nxt;
    end
  end

  // Pin flops; out of reset the line is released, so with inversion
  // on and open drain no interrupt shows until a flag is enabled
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_o_r  <= 1'b0;
      irq_oe_r <= 1'b0;
    end else begin
      irq_o_r  <= irq_o_nxt;
      irq_oe_r <= irq_oe_nxt;
    end
  end

  // Outputs straight from flops
  assign AVS_WAITREQUEST = waitreq_r;
  assign AVS_READDATA    = rdata_r;
  assign COMMAND         = cmd_r;
  assign CMD_START       = cmd_start_r;
  assign RECEIVER_OFF    = rcv_off_r;
  assign SOFT_SLEEP      = soft_sleep_r;
  assign IRQ_O           = irq_o_r;
  assign IRQ_OE          = irq_oe_r;

endmodule // cirq_top

// ===== tb/cirq_chk_sva.sv
// Port checker for the command and interrupt register block.
// Bound into cirq_top; sees its ports only, one clock domain.
`timescale 1ns/10ps
module cirq_chk #(
  parameter [15:0] CMD_KNOWN = 16'h80FF
) (
  input wire        REF_CLK,
  input wire        RST_N,
  input wire [4:0]  AVS_ADDRESS,
  input wire        AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0]  AVS_BYTEENABLE,
  input wire        AVS_WAITREQUEST,
  input wire [3:0]  COMMAND,
  input wire        CMD_START,
  input wire        RECEIVER_OFF,
  input wire        SOFT_SLEEP,
  input wire        IRQ_OE
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  wire [7:0] wd = AVS_WRITEDATA[7:0];
  // Command control write landing at this edge
  sequence cmd_wr;
    AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS[4:2] == 3'h1 && AVS_BYTEENABLE[0];
  endsequence
  // Wake-up holds the flag a while, then drops it
  sequence wake_run;
    SOFT_SLEEP [*3] ##[1:12] !SOFT_SLEEP;
  endsequence
  a_rcv_follow: assert property (cmd_wr |=> RECEIVER_OFF == $past(wd[5]))
    else $error("receiver off not taken");
  a_sleep_enter: assert property (cmd_wr ##0 (wd[4] && COMMAND != 4'hF) |=> SOFT_SLEEP)
    else $error("sleep not entered");
  a_sleep_block: assert property (
    cmd_wr ##0 (wd[4] && COMMAND == 4'hF && !SOFT_SLEEP) |=> !SOFT_SLEEP)
    else $error("sleep entered during soft reset");
  a_wake_hold: assert property (cmd_wr ##0 (!wd[4] && SOFT_SLEEP) |=> wake_run)
    else $error("wake-up timing wrong");
  a_start_known: assert property (
    cmd_wr ##0 (wd[3:0] != 4'h0 && CMD_KNOWN[wd[3:0]]) |=> CMD_START && COMMAND == $past(wd[3:0]))
    else $error("command not started");
  a_unknown_idle: assert property (
    cmd_wr ##0 !CMD_KNOWN[wd[3:0]] |=> COMMAND == 4'h0 && !CMD_START)
    else $error("unknown command not dropped");
  a_start_pulse: assert property (CMD_START |=> !CMD_START)
    else $error("start pulse too long");
  a_pin_reset: assert property ($rose(RST_N) |-> !IRQ_OE ##1 !IRQ_OE)
    else $error("irq line driven out of reset");
endmodule // cirq_chk

bind cirq_top cirq_chk #(.CMD_KNOWN(CMD_KNOWN)) cirq_chk_i (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .COMMAND(COMMAND), .CMD_START(CMD_START),
  .RECEIVER_OFF(RECEIVER_OFF), .SOFT_SLEEP(SOFT_SLEEP), .IRQ_OE(IRQ_OE)
);

// ===== tb/cirq_host.sv
// Host model: Avalon-MM master and the pulled-up interrupt line.
// Assumes a slave that answers by lowering waitrequest.
`timescale 1ns/10ps
module cirq_host (
  input  wire         clk,
  output logic [4:0]  address,
  output logic        read,
  output logic        write,
  output logic [31:0] wdata,
  input  wire  [31:0] rdata,
  input  wire         waitreq,
  input  wire         irq_o,
  input  wire         irq_oe,
  output wire         irq_pin
);
  // Board pull-up holds the line when the pin is released
  assign irq_pin = irq_oe ? irq_o : 1'b1;
  // Idle bus from time zero; unknown strobes would poison the slave
  initial begin
    address = 5'h00;
    read    = 1'b0;
    write   = 1'b0;
    wdata   = 32'h00000000;
  end
  // One access; request held until waitrequest is seen low
  task automatic xfer(input logic wr, input logic [2:0] idx, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk);
    address <= {idx, 2'b00};
    wdata   <= {24'h000000, d};
    write   <= wr;
    read    <= !wr;
    @(posedge clk);
    while (waitreq) @(posedge clk);
    q = rdata[7:0];
    write   <= 1'b0;
    read    <= 1'b0;
    address <= ~{idx, 2'b00}; // Released lines must not keep old values
    wdata   <= ~{24'h000000, d};
  endtask
endmodule // cirq_host

// ===== tb/test_cirq_top.sv
// Self-checking bench for the command and interrupt register block.
// Events driven directly; registers reached through the host model.
`timescale 1ns/10ps
module test_cirq_top;
  logic        clk;
  logic        rst_n;
  logic [8:0]  ev;
  wire  [4:0]  adr;
  wire  [31:0] wdat, rdat;
  wire         rd, wr_s, wreq, irq_o, irq_oe, pin, start, rcv, sleep;
  wire  [3:0]  cmd;
  wire  [31:0] rdat_w = rdat;
  int          fail_count, tests_run;
  logic [7:0]  rst_tab [0:6] = '{8'h00, 8'h20, 8'h80, 8'h00, 8'h14, 8'h00, 8'h00};
  cirq_top #(.WAKE_CYCLES(12'h008)) cirq_top_i (.REF_CLK(clk), .RST_N(rst_n),
    .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr_s), .AVS_WRITEDATA(wdat),
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
    .CMD_DONE(ev[4]), .TX_DONE_SET(ev[6]), .RX_DONE_SET(ev[5]), .HIGH_ALERT_SET(ev[3]),
    .LOW_ALERT_SET(ev[2]), .ERROR_SET(ev[1]), .TIMER_EXPIRY_SET(ev[0]),
    .EXT_INPUT_ACTIVITY_SET(ev[7]), .CRC_DONE_SET(ev[8]), .COMMAND(cmd),
    .CMD_START(start), .RECEIVER_OFF(rcv), .SOFT_SLEEP(sleep), .IRQ_O(irq_o), .IRQ_OE(irq_oe));
  cirq_host cirq_host_i (.clk(clk), .address(adr), .read(rd), .write(wr_s), .wdata(wdat),
    .rdata(rdat_w), .waitreq(wreq), .irq_o(irq_o), .irq_oe(irq_oe), .irq_pin(pin));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rchk(input logic [2:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    cirq_host_i.xfer(1'b0, idx, 8'h00, q);
    chk("register", q, exp);
  endtask
  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    logic [7:0] q;
    cirq_host_i.xfer(1'b1, idx, d, q);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
  endtask
  task give_verdict;
    if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    fail_count++;
    give_verdict;
  end
  initial begin
    ev = 9'h000;
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("irq line", pin, 8'h01);
    for (int i = 0; i < 7; i++) rchk(i[2:0], rst_tab[i]);
    wr(0, 8'hFF);
    rchk(0, 8'h00);
    wr(3, 8'hFF);
    rchk(3, 8'h94);
    wr(3, 8'h00);
    wr(4, 8'h7F);
    rchk(4, 8'h00);
    wr(4, 8'h83);
    rchk(4, 8'h03);
    wr(4, 8'h01);
    rchk(4, 8'h02);
    wr(4, 8'h02);
    // Each event but CMD_DONE via its own enable; inverted open drain pulls the line low
    for (int i = 0; i < 9; i++) begin
      if (i == 4) continue;
      if (i < 7) wr(2, 8'h80 | (8'h01 << i));
      else wr(3, (i == 7) ? 8'h10 : 8'h04);
      pulse(i);
      repeat (3) @(posedge clk);
      chk("irq line", pin, 8'h00);
      if (i < 7) wr(4, 8'h01 << i);
      else wr(5, (i == 7) ? 8'h10 : 8'h04);
      repeat (3) @(posedge clk);
      chk("irq line", pin, 8'h01);
      wr(3, 8'h00);
    end
    // Push-pull without inversion drives the idle level itself
    wr(3, 8'h80);
    wr(2, 8'h00);
    repeat (3) @(posedge clk);
    chk("irq drive", {irq_oe, pin}, 8'h02);
    wr(1, 8'h23);
    @(posedge clk);
    chk("command pins", {3'b000, start, cmd}, 8'h13);
    rchk(1, 8'h23);
    pulse(4);
    rchk(1, 8'h20);
    rchk(4, 8'h10);
    wr(4, 8'h10);
    wr(1, 8'h20);
    rchk(4, 8'h00);
    wr(1, 8'h29);
    rchk(1, 8'h20);
    rchk(4, 8'h10);
    wr(1, 8'h10);
    @(posedge clk);
    chk("sleep pins", {sleep, rcv}, 8'h02);
    wr(1, 8'h00);
    rchk(1, 8'h10);
    repeat (12) @(posedge clk);
    rchk(1, 8'h00);
    wr(1, 8'h0F);
    wr(1, 8'h1F);
    rchk(1, 8'h0F);
    give_verdict;
  end
endmodule // test_cirq_top
